/* dv/exp_board_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Expansion board on the nibble bus: decodes address cycles, logs writes, answers reads.
module exp_board_model #(
  parameter logic [11:0] HERE = 12'h5A3
) (
  input wire logic pclk,
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_oe,
  output logic [7:0] port_in
);
  logic [11:0] adr = 12'h000;
  logic strobe_d = 1'b0;
  logic [15:0] wlog[$];
  int rst_run = 0;
  int rst_len = 0;
  logic drv;
  logic [3:0] resp;

  // Nibbles are taken at the rising strobe; the host holds them for the whole cycle.
  always @(posedge pclk) begin
    strobe_d <= port_out[7];
    if (port_out[7] && !strobe_d) begin
      case (port_out[6:4])
        3'h1: adr[11:8] <= port_out[3:0];
        3'h2: adr[7:4] <= port_out[3:0];
        3'h3: adr[3:0] <= port_out[3:0];
        3'h4: wlog.push_back({adr, port_out[3:0]});
        default: ;
      endcase
    end
    // The reset pulse length is kept so the bench can judge it.
    if (port_out[7] && port_out[6:4] == 3'h0) begin
      rst_run <= rst_run + 1;
    end else if (rst_run != 0) begin
      rst_len <= rst_run;
      rst_run <= 0;
    end
  end

  // Only the addressed board answers, and only while the host has released the lines.
  assign drv = port_out[7] && port_out[6:4] >= 3'h5 && port_oe[3:0] == 4'h0 && adr == HERE;
  assign resp = {port_out[6:4], 1'b0};
  // Undriven lines float high through the pull-ups, so an absent board reads bit 0 as one.
  assign port_in = (port_oe & port_out) | (~port_oe & {4'hF, drv ? resp : 4'hF});
endmodule : exp_board_model

/* dv/pio_nibble_expansion_bus_host_tb.sv */
`timescale 1ns/1ps
`include "pio_nibble_defines.svh"
module pio_nibble_expansion_bus_host_tb;
  localparam logic [11:0] HERE = 12'h5A3;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, pin, pout, poe;
  logic [31:0] pwdata, prdata, rd, d;
  logic [11:0] a, da;
  logic [5:0] b;
  logic [2:0] r;
  logic s;
  int fails, comparisons, seed, cyc, t0;

  pio_nibble_bus_host #(.CLK_MHZ(20), .SETTLE_US(2)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_parallel_port_a_in(pin), .host_parallel_port_a_out(pout),
    .host_parallel_port_a_oe(poe));
  exp_board_model #(.HERE(HERE)) board (.pclk(pclk), .port_out(pout), .port_oe(poe), .port_in(pin));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, cycle count and watchdog.
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial cyc = 0;
  always @(posedge pclk) cyc <= cyc + 1;
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    $display("BAD watchdog expired");
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // No answer time is assumed here; only the watchdog ends a wait.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Issue a command, then poll the busy flag; the final status lands in rd.
  task automatic cmd(input logic [4:0] op, input logic [5:0] bd, input logic [2:0] rl, input logic st);
    apb(1'b1, `REG_CMD, {17'h0, st, rl, bd, op}, rd, err);
    do begin
      apb(1'b0, `REG_STATUS, 32'h0, rd, err);
    end while (rd[0] !== 1'b0);
  endtask : cmd

  // Compare the oldest write the board saw with the expected address and nibble.
  task automatic ew(input logic [11:0] ea, input logic [3:0] en);
    logic [15:0] g;
    g = 16'hXXXX;
    if (board.wlog.size() > 0) g = board.wlog.pop_front();
    chk("bus write", {16'h0, ea, en}, {16'h0, g});
  endtask : ew

  function automatic logic [11:0] swap12(input logic [11:0] v);
    return {v[3:0], v[7:4], v[11:8]};
  endfunction : swap12

  function automatic logic [11:0] brd(input logic [5:0] n, input logic dac);
    return {n[5:3], n[2], 2'b00, dac, n[1], 3'b000, n[0]};
  endfunction : brd

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: corner cases first, then random traffic per command family.
  initial begin
    seed = 32'h4cc20285;
    fails = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    chk("oe in reset", 32'h0, {24'h0, poe});
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk("oe after reset", 32'h0000_00FF, {24'h0, poe});
    apb(1'b0, 8'h3C, 32'h0, rd, err);
    chk("unmapped error", 32'h1, {31'h0, err});
    cmd(pio_nibble_pkg::op_write, 6'h00, 3'h0, 1'b0);
    chk("write without address", 32'h1, {31'h0, rd[2]});
    // Two writes per loaded address: the second must reuse it.
    repeat (5) begin
      a = 12'($random(seed));
      apb(1'b1, `REG_ADDR, {20'h0, a}, rd, err);
      cmd(pio_nibble_pkg::op_set_addr, 6'h00, 3'h0, 1'b0);
      chk("address loaded", 32'h1, {31'h0, rd[4]});
      repeat (2) begin
        d = $random(seed);
        apb(1'b1, `REG_DATA, d, rd, err);
        apb(1'b0, `REG_DATA, 32'h0, rd, err);
        chk("data readback", {20'h0, d[11:0]}, rd);
        cmd(pio_nibble_pkg::op_write, 6'h00, 3'h0, 1'b0);
        ew(swap12(a), d[3:0]);
      end
      apb(1'b0, `REG_CURADDR, 32'h0, rd, err);
      chk("current address", {20'h0, a}, {20'h0, rd[11:0]});
      chk("mapped error", 32'h0, {31'h0, err});
    end
    // Each read kind returns its own nibble from the present board.
    apb(1'b1, `REG_ADDR, {20'h0, swap12(HERE)}, rd, err);
    cmd(pio_nibble_pkg::op_set_addr, 6'h00, 3'h0, 1'b0);
    for (int k = 0; k < 3; k++) begin
      cmd(5'(pio_nibble_pkg::op_read0 + k), 6'h00, 3'h0, 1'b0);
      chk("read nibble", {28'h0, 3'(5 + k), 1'b0}, {28'h0, rd[11:8]});
    end
    cmd(pio_nibble_pkg::op_poll, 6'h00, 3'h0, 1'b0);
    chk("poll present", 32'h1, {31'h0, rd[3]});
    apb(1'b1, `REG_ADDR, {20'h0, swap12(HERE ^ 12'h001)}, rd, err);
    cmd(pio_nibble_pkg::op_poll, 6'h00, 3'h0, 1'b0);
    chk("poll absent", 32'h0, {31'h0, rd[3]});
    // Relay boards, extreme board numbers first.
    for (int k = 0; k < 6; k++) begin
      b = (k == 0) ? 6'h3F : (k == 1) ? 6'h00 : 6'($random(seed));
      r = (k == 0) ? 3'h7 : 3'($random(seed));
      s = (k == 1) ? 1'b0 : 1'($random(seed));
      cmd(pio_nibble_pkg::op_relay, b, r, s);
      ew(brd(b, 1'b0), {r, s});
    end
    // Converter board: refused before init, then every staged and direct operation.
    b = 6'($random(seed));
    da = brd(b, 1'b1);
    cmd(pio_nibble_pkg::op_dac_addr, b, 3'h0, 1'b0);
    chk("init cleared", 32'h0, {31'h0, rd[5]});
    cmd(pio_nibble_pkg::op_dac_load1, 6'h00, 3'h0, 1'b0);
    chk("load before init", 32'h1, {31'h0, rd[2]});
    chk("no bus traffic", 32'h0, board.wlog.size());
    cmd(pio_nibble_pkg::op_dac_init, 6'h00, 3'h0, 1'b0);
    ew(da, 4'h0);
    chk("init flag", 32'h1, {31'h0, rd[5]});
    for (int k = 0; k < 6; k++) begin
      d = $random(seed);
      apb(1'b1, `REG_DATA, d, rd, err);
      cmd(5'(pio_nibble_pkg::op_dac_load1 + k), 6'h00, 3'h0, 1'b0);
      ew(da, 4'(k + 1));
      if (k != 2 && k != 3) begin
        ew(da, d[11:8]);
        ew(da, d[7:4]);
        ew(da, d[3:0]);
      end
    end
    // Bus reset: pulse, settle, refusal while settling, address unloaded.
    apb(1'b1, `REG_CMD, {27'h0, pio_nibble_pkg::op_bus_reset}, rd, err);
    t0 = cyc;
    apb(1'b0, `REG_STATUS, 32'h0, rd, err);
    chk("settling flag", 32'h1, {31'h0, rd[1]});
    cmd(pio_nibble_pkg::op_set_addr, 6'h00, 3'h0, 1'b0);
    chk("command while settling", 32'h1, {31'h0, rd[2]});
    chk("settle long enough", 32'h1, {31'h0, (cyc - t0) >= 60});
    chk("reset pulse clocks", `BUSRST_CYC, board.rst_len);
    cmd(pio_nibble_pkg::op_write, 6'h00, 3'h0, 1'b0);
    chk("write after reset", 32'h1, {31'h0, rd[2]});
    conclude();
  end
endmodule : pio_nibble_expansion_bus_host_tb

/* logic/pio_nibble_bus_host.sv */
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "pio_nibble_defines.svh"
// How it works
// - Bus runs over one 8-bit port; only 4-bit data boards are served.
// - No attention line exists toward the boards.
// - A current 12-bit target address is kept until software loads another; a bus reset marks it unloaded but keeps its value.
// - Supplied address has first and third nibbles exchanged.
// - A write puts the low four bits of the value on the bus.
// - Three read cycle types each return four bits in the low bits.
// - A bus reset operation resets all attached boards.
// - After bus reset, a settle wait blocks every board access.
// - Poll loads the address, runs read cycle 0, reports bit 0 low as presence.
// - Every data cycle is preceded by three address nibble cycles.
// - Relay board number maps to address pppx000y000z.
// - Jumper bits read 0 when closed, 1 when open.
// - Relay command picks relay 0 to 7; state 1 energises, 0 releases.
// - Converter board number maps to address pppx001y000z.
// - Stage load writes a 12-bit value into a holding register only.
// - Transfer copies holding register into the output register.
// - Converter board must be initialised before data is written.
// - Direct set uses only the low 12 bits of the value.
// - Converter operations need the board address loaded first.
module pio_nibble_bus_host #(
  parameter int unsigned CLK_MHZ = `CLK_MHZ,
  parameter int unsigned SETTLE_US = `SETTLE_US_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] host_parallel_port_a_in,
  output logic [7:0] host_parallel_port_a_out,
  output logic [7:0] host_parallel_port_a_oe
);

  localparam logic [7:0] STB = 8'(`STROBE_CYC);
  localparam logic [7:0] LAST = 8'(`STROBE_CYC + 1);
  localparam logic [7:0] RST_LAST = 8'(`BUSRST_CYC - 1);
  // The settle wait grows with the clock so wall time never shrinks.
  localparam logic [31:0] SETTLE_LAST = 32'(SETTLE_US * CLK_MHZ - 1);

  pio_nibble_pkg::adapter_state_t s;
  pio_nibble_pkg::adapter_state_t n;
  pio_nibble_pkg::op_t cmd;
  pio_nibble_pkg::cyc_t code;
  logic [3:0] nib;
  logic rd;
  logic access;

  ////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Exchanging nibbles one and three is its own inverse.
  function automatic logic [11:0] nib_swap(input logic [11:0] v);
    return {v[3:0], v[7:4], v[11:8]};
  endfunction : nib_swap

  // Board number pppxyz; jumper bits pass as given, closed is zero.
  function automatic logic [11:0] board_addr(input logic [5:0] b, input logic dac);
    return {b[5:3], b[2], 2'b00, dac, b[1], 3'b000, b[0]};
  endfunction : board_addr

  function automatic logic is_read(input pio_nibble_pkg::cyc_t k);
    return (k == pio_nibble_pkg::cyc_rd0) || (k == pio_nibble_pkg::cyc_rd1) ||
           (k == pio_nibble_pkg::cyc_spare);
  endfunction : is_read

  function automatic logic addr_hit(input logic [7:0] a);
    return (a == `REG_CMD) || (a == `REG_ADDR) || (a == `REG_DATA) ||
           (a == `REG_STATUS) || (a == `REG_CURADDR);
  endfunction : addr_hit

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // One process computes every next value from the registered state.
  always_comb begin
    n = s;
    cmd = pio_nibble_pkg::op_t'(pwdata[`CMD_OP]);
    code = pio_nibble_pkg::cyc_reset;
    nib = 4'h0;
    rd = 1'b0;
    access = psel & penable;

    // Three-stage input synchroniser; a change counts once stages agree.
    n.sync1 = host_parallel_port_a_in[`PORT_DATA];
    n.sync2 = s.sync1;
    n.sync3 = s.sync2;
    if (s.sync2 == s.sync3) begin
      n.din = s.sync3;
    end

    // APB answers one cycle into the access phase.
    n.pready = access & ~s.pready;
    n.pslverr = access & ~s.pready & ~addr_hit(paddr);
    if (access && !s.pready && !pwrite) begin
      case (paddr)
        `REG_ADDR: n.prdata = {20'h00000, s.addr_reg};
        `REG_DATA: n.prdata = {20'h00000, s.data_reg};
        `REG_CURADDR: n.prdata = {20'h00000, nib_swap(s.cur_addr)};
        `REG_STATUS: begin
          n.prdata = 32'h00000000;
          n.prdata[`STS_BUSY] = (s.st != pio_nibble_pkg::idle);
          n.prdata[`STS_SETTLING] = (s.st == pio_nibble_pkg::bus_reset) ||
                                    (s.st == pio_nibble_pkg::settling);
          n.prdata[`STS_REFUSED] = s.refused;
          n.prdata[`STS_PRESENT] = s.present;
          n.prdata[`STS_LOADED] = s.loaded;
          n.prdata[`STS_DACINIT] = s.dac_init;
          n.prdata[`STS_RESULT] = s.result;
        end
        default: n.prdata = 32'h00000000;
      endcase
    end

    // Writes take effect on the edge where the master sees pready.
    if (access && s.pready && pwrite) begin
      case (paddr)
        `REG_ADDR: n.addr_reg = pwdata[11:0];
        `REG_DATA: n.data_reg = pwdata[11:0];
        `REG_CMD: begin
          if (s.st != pio_nibble_pkg::idle) begin
            // Busy or settling: the command is dropped and flagged.
            n.refused = 1'b1;
          end else begin
            n.refused = 1'b0;
            n.phase = 8'h00;
            n.aidx = 2'b00;
            n.didx = 2'b00;
            n.dcnt = 3'h1;
            n.poll = 1'b0;
            n.nibs = {12'h000, s.data_reg[3:0]};
            case (cmd)
              pio_nibble_pkg::op_set_addr: begin
                n.cur_addr = nib_swap(s.addr_reg);
                n.loaded = 1'b1;
                n.dac_init = 1'b0;
              end
              pio_nibble_pkg::op_write,
              pio_nibble_pkg::op_read0,
              pio_nibble_pkg::op_read1,
              pio_nibble_pkg::op_read_spare: begin
                if (!s.loaded) begin
                  n.refused = 1'b1;
                end else begin
                  n.st = pio_nibble_pkg::addressing;
                  n.kind = (cmd == pio_nibble_pkg::op_write) ? pio_nibble_pkg::cyc_write :
                           (cmd == pio_nibble_pkg::op_read0) ? pio_nibble_pkg::cyc_rd0 :
                           (cmd == pio_nibble_pkg::op_read1) ? pio_nibble_pkg::cyc_rd1 :
                           pio_nibble_pkg::cyc_spare;
                end
              end
              pio_nibble_pkg::op_bus_reset: begin
                n.st = pio_nibble_pkg::bus_reset;
                n.loaded = 1'b0;
                n.dac_init = 1'b0;
              end
              pio_nibble_pkg::op_poll: begin
                n.cur_addr = nib_swap(s.addr_reg);
                n.loaded = 1'b1;
                n.dac_init = 1'b0;
                n.poll = 1'b1;
                n.kind = pio_nibble_pkg::cyc_rd0;
                n.st = pio_nibble_pkg::addressing;
              end
              pio_nibble_pkg::op_relay: begin
                // Relay nibble is relay number over the on/off bit.
                n.cur_addr = board_addr(pwdata[`CMD_BOARD], 1'b0);
                n.loaded = 1'b1;
                n.dac_init = 1'b0;
                n.nibs = {12'h000, pwdata[`CMD_RELAY], pwdata[`CMD_STATE]};
                n.kind = pio_nibble_pkg::cyc_write;
                n.st = pio_nibble_pkg::addressing;
              end
              pio_nibble_pkg::op_dac_addr: begin
                n.cur_addr = board_addr(pwdata[`CMD_BOARD], 1'b1);
                n.loaded = 1'b1;
                n.dac_init = 1'b0;
              end
              pio_nibble_pkg::op_dac_init,
              pio_nibble_pkg::op_dac_xfer1,
              pio_nibble_pkg::op_dac_xfer2: begin
                if (!s.loaded) begin
                  n.refused = 1'b1;
                end else begin
                  n.kind = pio_nibble_pkg::cyc_write;
                  n.st = pio_nibble_pkg::addressing;
                  n.dac_init = s.dac_init | (cmd == pio_nibble_pkg::op_dac_init);
                  n.nibs[3:0] = (cmd == pio_nibble_pkg::op_dac_init) ? `DAC_INIT_NIB :
                                (cmd == pio_nibble_pkg::op_dac_xfer1) ? `DAC_XFER1_NIB :
                                `DAC_XFER2_NIB;
                end
              end
              pio_nibble_pkg::op_dac_load1,
              pio_nibble_pkg::op_dac_load2,
              pio_nibble_pkg::op_dac_set1,
              pio_nibble_pkg::op_dac_set2: begin
                // Data ops need both a loaded address and an initialised board.
                if (!s.loaded || !s.dac_init) begin
                  n.refused = 1'b1;
                end else begin
                  n.kind = pio_nibble_pkg::cyc_write;
                  n.st = pio_nibble_pkg::addressing;
                  n.dcnt = 3'h4;
                  n.nibs[15:4] = {s.data_reg[3:0], s.data_reg[7:4], s.data_reg[11:8]};
                  n.nibs[3:0] = (cmd == pio_nibble_pkg::op_dac_load1) ? `DAC_LOAD1_NIB :
                                (cmd == pio_nibble_pkg::op_dac_load2) ? `DAC_LOAD2_NIB :
                                (cmd == pio_nibble_pkg::op_dac_set1) ? `DAC_SET1_NIB :
                                `DAC_SET2_NIB;
                end
              end
              default: n.refused = 1'b0;
            endcase
          end
        end
        default: n.refused = s.refused;
      endcase
    end

    // Bus sequencer: setup phase, strobe phases, then one hold phase.
    case (s.st)
      pio_nibble_pkg::addressing,
      pio_nibble_pkg::data_cyc: begin
        if (s.st == pio_nibble_pkg::addressing) begin
          // Most significant nibble goes out first.
          code = pio_nibble_pkg::cyc_t'(3'(s.aidx) + 3'h1);
          nib = s.cur_addr[4'(4'd8 - {s.aidx, 2'b00}) +: 4];
        end else begin
          code = s.kind;
          nib = s.nibs[{s.didx, 2'b00} +: 4];
          rd = is_read(s.kind);
        end
        n.port_out[`PORT_STROBE] = (s.phase != 8'h00) && (s.phase != LAST);
        n.port_out[`PORT_CODE] = code;
        n.port_out[`PORT_DATA] = rd ? 4'h0 : nib;
        // Data lines are released while the board answers a read.
        n.port_oe = {4'hF, {4{~rd}}};
        if (rd && s.phase == STB) begin
          n.result = s.din;
          if (s.poll) begin
            n.present = ~s.din[0];
          end
        end
        if (s.phase == LAST) begin
          n.phase = 8'h00;
          if (s.st == pio_nibble_pkg::addressing) begin
            n.aidx = s.aidx + 2'b01;
            if (s.aidx == 2'b10) begin
              n.aidx = 2'b00;
              n.st = pio_nibble_pkg::data_cyc;
            end
          end else if (3'(s.didx) + 3'h1 == s.dcnt) begin
            n.st = pio_nibble_pkg::idle;
          end else begin
            // Each further nibble is again preceded by its address.
            n.didx = s.didx + 2'b01;
            n.st = pio_nibble_pkg::addressing;
          end
        end else begin
          n.phase = s.phase + 8'h01;
        end
      end
      pio_nibble_pkg::bus_reset: begin
        n.port_out = {1'b1, pio_nibble_pkg::cyc_reset, 4'h0};
        n.port_oe = 8'hFF;
        n.phase = s.phase + 8'h01;
        n.settle = 32'h00000000;
        if (s.phase == RST_LAST) begin
          n.phase = 8'h00;
          n.st = pio_nibble_pkg::settling;
        end
      end
      pio_nibble_pkg::settling: begin
        n.port_out = 8'h00;
        n.port_oe = 8'hFF;
        n.settle = s.settle + 32'h00000001;
        if (s.settle == SETTLE_LAST) begin
          n.st = pio_nibble_pkg::idle;
        end
      end
      default: begin
        n.port_out = 8'h00;
        n.port_oe = 8'hFF;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register and outputs.

  // Port pins stay undriven under reset so boards see no false cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Port A carries strobe, cycle code and nibble; no attention input.
  assign host_parallel_port_a_out = s.port_out;
  assign host_parallel_port_a_oe = s.port_oe;
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("APB access not answered in one cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  data_after_addr_a: assert property (s.st == pio_nibble_pkg::data_cyc &&
      $past(s.st) != pio_nibble_pkg::data_cyc |-> $past(s.st) == pio_nibble_pkg::addressing)
    else $error("data cycle without address cycles");
  first_nibble_a: assert property (s.st == pio_nibble_pkg::addressing && s.aidx == 2'b00 &&
      s.phase == 8'h01 |=> host_parallel_port_a_out[3:0] == s.cur_addr[11:8])
    else $error("first address nibble is not the top nibble");
  read_release_a: assert property (s.st == pio_nibble_pkg::data_cyc &&
      is_read(s.kind) |=> host_parallel_port_a_oe[3:0] == 4'h0)
    else $error("data lines driven during a read");
  reset_drive_a: assert property (s.st == pio_nibble_pkg::bus_reset |=>
      host_parallel_port_a_out[7] && host_parallel_port_a_out[6:4] == 3'h0)
    else $error("bus reset not driven");
  settle_hold_a: assert property (s.st == pio_nibble_pkg::settling &&
      s.settle != SETTLE_LAST |=> s.st == pio_nibble_pkg::settling)
    else $error("settle wait cut short");
  poll_result_a: assert property (s.st == pio_nibble_pkg::data_cyc && s.poll &&
      s.phase == STB |=> s.present == !$past(s.din[0]))
    else $error("poll result does not mirror bit 0");
  dac_guard_a: assert property (psel && penable && pready && pwrite &&
      paddr == `REG_CMD && s.st == pio_nibble_pkg::idle && !s.dac_init &&
      pwdata[4:0] == 5'h0B |=> s.st == pio_nibble_pkg::idle && s.refused)
    else $error("stage load accepted before initialisation");
  relay_addr_a: assert property (psel && penable && pready && pwrite &&
      paddr == `REG_CMD && s.st == pio_nibble_pkg::idle && pwdata[4:0] == 5'h08
      |=> s.cur_addr == board_addr($past(pwdata[10:5]), 1'b0))
    else $error("relay board address wrong");

  // Sequencer checks; a miscount here would shift every board address by one nibble.
  address_order_a: assert property (s.st == pio_nibble_pkg::addressing && s.phase == LAST &&
      s.aidx == 2'b10 |=> s.st == pio_nibble_pkg::data_cyc && s.aidx == 2'b00)
    else $error("data cycle does not follow the third address nibble");
  read_capture_a: assert property (s.st == pio_nibble_pkg::data_cyc && is_read(s.kind) &&
      s.phase == STB |=> s.result == $past(s.din))
    else $error("read nibble not captured at the last strobe clock");
  strobe_idle_a: assert property (s.st == pio_nibble_pkg::idle |->
      !host_parallel_port_a_out[`PORT_STROBE])
    else $error("strobe raised while the sequencer is idle");
  // Bus reset and refusal checks.
  busy_refuse_a: assert property (psel && penable && pready && pwrite &&
      paddr == `REG_CMD && s.st != pio_nibble_pkg::idle |=> s.refused)
    else $error("command accepted while busy or settling");
  settle_start_a: assert property (s.st == pio_nibble_pkg::bus_reset && s.phase == RST_LAST |=>
      s.st == pio_nibble_pkg::settling && s.settle == 32'h00000000)
    else $error("settle wait did not start from zero");
  reset_unload_a: assert property (s.st == pio_nibble_pkg::bus_reset |->
      !s.loaded && !s.dac_init)
    else $error("address still loaded during bus reset");

endmodule : pio_nibble_bus_host

/* logic/pio_nibble_defines.svh */
`ifndef PIO_NIBBLE_DEFINES_SVH
`define PIO_NIBBLE_DEFINES_SVH

// Register byte offsets on the APB side.
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_DATA 8'h08
`define REG_STATUS 8'h0C
`define REG_CURADDR 8'h10

// Command word fields.
`define CMD_OP 4:0
`define CMD_BOARD 10:5
`define CMD_RELAY 13:11
`define CMD_STATE 14

// Status word fields.
`define STS_BUSY 0
`define STS_SETTLING 1
`define STS_REFUSED 2
`define STS_PRESENT 3
`define STS_LOADED 4
`define STS_DACINIT 5
`define STS_RESULT 11:8

// Port A layout: strobe, cycle code, data nibble.
`define PORT_STROBE 7
`define PORT_CODE 6:4
`define PORT_DATA 3:0

// Converter board control nibbles.
`define DAC_INIT_NIB 4'h0
`define DAC_LOAD1_NIB 4'h1
`define DAC_LOAD2_NIB 4'h2
`define DAC_XFER1_NIB 4'h3
`define DAC_XFER2_NIB 4'h4
`define DAC_SET1_NIB 4'h5
`define DAC_SET2_NIB 4'h6

// Timing, rounded up to whole cycles.
`define CLK_MHZ 20
`define STROBE_NS 300
`define STROBE_CYC ((`STROBE_NS * `CLK_MHZ + 999) / 1000)
`define BUSRST_NS 1000
`define BUSRST_CYC ((`BUSRST_NS * `CLK_MHZ + 999) / 1000)
`define SETTLE_US_DEFAULT 1000

`endif

/* logic/pio_nibble_pkg.sv */
package pio_nibble_pkg;

  // Sequencer states, Gray coded along idle, address, data.
  typedef enum logic [2:0] {
    idle = 3'b000,
    addressing = 3'b001,
    data_cyc = 3'b011,
    bus_reset = 3'b010,
    settling = 3'b110
  } seq_state_t;

  // Cycle codes placed on port A bits 6..4.
  typedef enum logic [2:0] {
    cyc_reset = 3'h0,
    cyc_adr0 = 3'h1,
    cyc_adr1 = 3'h2,
    cyc_adr2 = 3'h3,
    cyc_write = 3'h4,
    cyc_rd0 = 3'h5,
    cyc_rd1 = 3'h6,
    cyc_spare = 3'h7
  } cyc_t;

  // Software commands.
  typedef enum logic [4:0] {
    op_nop = 5'h00,
    op_set_addr = 5'h01,
    op_write = 5'h02,
    op_read0 = 5'h03,
    op_read1 = 5'h04,
    op_read_spare = 5'h05,
    op_bus_reset = 5'h06,
    op_poll = 5'h07,
    op_relay = 5'h08,
    op_dac_addr = 5'h09,
    op_dac_init = 5'h0A,
    op_dac_load1 = 5'h0B,
    op_dac_load2 = 5'h0C,
    op_dac_xfer1 = 5'h0D,
    op_dac_xfer2 = 5'h0E,
    op_dac_set1 = 5'h0F,
    op_dac_set2 = 5'h10
  } op_t;

  // Whole state of the adapter.
  typedef struct packed {
    seq_state_t st;
    cyc_t kind;
    logic [7:0] phase;
    logic [31:0] settle;
    logic [1:0] aidx;
    logic [1:0] didx;
    logic [2:0] dcnt;
    logic [15:0] nibs;
    logic [11:0] cur_addr;
    logic [11:0] addr_reg;
    logic [11:0] data_reg;
    logic [3:0] result;
    logic poll;
    logic present;
    logic refused;
    logic loaded;
    logic dac_init;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] din;
    logic [7:0] port_out;
    logic [7:0] port_oe;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } adapter_state_t;

endpackage : pio_nibble_pkg
